// >>> hw/thp_regs.vh
// Register map, codes and timing constants of the touch host object interface.
//----------------------------------------------------------------------------
// How it works
// [RULE_01] After power-up the device pulls change_notify_n low: a message waits.
// [RULE_02] The host treats a notify line that never falls after power-up as a fault.
// [RULE_03] After power-up or reset the host reads all pending messages.
// [RULE_04] At start-up the host checks that no configuration error is reported.
// [RULE_05] The host first reads the object table and lists every object start.
// [RULE_06] The host derives report identifier ranges from the object table.
// [RULE_07] Host writes a command code to the command object; the device acts on it.
// [RULE_08] The host configures object fields and enables optional objects first.
// [RULE_09] All status goes to the message object; the host reads only that. Here overflow, busy and queue count are also in the status register.
// [RULE_10] Each new message in the message object asserts change_notify_n.
// [RULE_11] The host waits for change_notify_n rather than polling for messages.
// [RULE_12] Every object field resets to zero, leaving its function disabled.
// [RULE_13] After configuring, the host issues backup to store settings.
// [RULE_14] The host keeps stores to nonvolatile memory within the rated count.
// [RULE_15] The host programs power and acquisition objects before operation.
// [RULE_16] The host enables each touch object and sets its origin and size.
// [RULE_17] Touch objects report messages only once their reporting is enabled.
// [RULE_18] The host enables reporting of support objects before expecting messages.
// [RULE_19] Change_notify_n falls about 40 ms after power-on.
// [RULE_20] Change_notify_n falls about 40 ms after a hardware reset.
// [RULE_21] Change_notify_n falls about 64 ms after a reset command.
// [RULE_22] Change_notify_n stays low until every pending message is read; here a reset command empties the queue and releases it without reads.
//----------------------------------------------------------------------------
`ifndef THP_REGS_VH
`define THP_REGS_VH

//----------------------------------------------------------------------------
// Register byte offsets and address pages
//----------------------------------------------------------------------------
`define THP_REG_STATUS    10'h000
`define THP_REG_COMMAND   10'h004
`define THP_REG_MESSAGE   10'h008
`define THP_REG_NVM_CNT   10'h00c
`define THP_REG_REPORT_EN 10'h010
`define THP_OBJ_TBL_PAGE  6'h04
`define THP_CFG_BASE      10'h100
`define THP_CFG_PAGE      4'h4

//----------------------------------------------------------------------------
// Status bits
//----------------------------------------------------------------------------
`define THP_ST_NOTIFY     0
`define THP_ST_BUSY       1
`define THP_ST_OVF        2

//----------------------------------------------------------------------------
// Command codes, message types and report identifiers
//----------------------------------------------------------------------------
`define THP_CMD_RESET     8'h01
`define THP_CMD_BACKUP    8'h02
`define THP_CMD_CALIB     8'h03
`define THP_MSG_RESET     8'h80
`define THP_MSG_CALIB     8'h10
`define THP_MSG_BACKUP    8'h20
`define THP_RID_CMD       8'h01
`define THP_RID_NONE      8'hff

//----------------------------------------------------------------------------
// Timing
//----------------------------------------------------------------------------
`define THP_CLK_KHZ       25000
`define THP_POR_MS        40
`define THP_SWR_MS        64

`endif

// >>> hw/thp_delay_timer.v
// One-shot down counter that times the start-up delay before the first message.
`timescale 1ns/1ps

module thp_delay_timer
#(
   parameter CNT_W = 21
)
(
   input  wire             clk_in,   // System clock.
   input  wire             rst_in,   // Synchronous reset, active high.
   input  wire             start_in, // Pulse that loads and starts the count.
   input  wire [CNT_W-1:0] load_in,  // Cycles to wait.
   output reg              busy_out, // High while counting.
   output reg              done_out  // One-cycle pulse when the wait ends.
);

   reg [CNT_W-1:0] cnt_r;

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         cnt_r    <= {CNT_W{1'b0}};
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end
      else if (start_in)
      begin
         cnt_r    <= load_in;
         busy_out <= 1'b1;
         done_out <= 1'b0;
      end
      else if (busy_out && cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1})
      begin
         cnt_r    <= {CNT_W{1'b0}};
         busy_out <= 1'b0;
         done_out <= 1'b1;
      end
      else
      begin
         cnt_r    <= busy_out ? cnt_r - {{(CNT_W-1){1'b0}}, 1'b1} : cnt_r;
         done_out <= 1'b0;
      end
   end

endmodule

// >>> hw/thp_object_if.v
// Host-facing object protocol: command object, configuration fields, message queue.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "thp_regs.vh"

module thp_object_if
#(
   parameter POR_CYC = `THP_POR_MS * `THP_CLK_KHZ,
   parameter SWR_CYC = `THP_SWR_MS * `THP_CLK_KHZ,
   parameter Q_AW    = 3
)
(
   input  wire        clk_in,              // System clock, 25 MHz.
   input  wire        rst_in,              // Synchronous reset, active high.
   input  wire [9:0]  avs_address_in,      // Byte address.
   input  wire        avs_read_in,         // Read request.
   input  wire        avs_write_in,        // Write request.
   input  wire [31:0] avs_writedata_in,    // Write data.
   input  wire [3:0]  avs_byteenable_in,   // Byte enables.
   input  wire        touch_valid_in,      // Touch report from the sensing core.
   input  wire [1:0]  touch_obj_in,        // Object that produced the report.
   input  wire [15:0] touch_data_in,       // Report payload.
   output reg  [31:0] avs_readdata_out,    // Read data.
   output reg         avs_waitrequest_out, // Low for the answering cycle.
   output reg         change_notify_n_out, // Low while messages are pending.
   output reg         calibrate_out        // One-cycle pulse: start calibration.
);

   localparam DEPTH   = 1 << Q_AW;
   localparam NUM_CFG = 16;
   localparam CNT_W   = 21;

   //-------------------------------------------------------------------------
   // Helpers
   //-------------------------------------------------------------------------
   function [23:0] mk_msg;
      input [7:0] rid;
      input [7:0] kind;
      input [7:0] info;
      begin
         mk_msg = {rid, kind, info};
      end
   endfunction

   function [31:0] obj_entry;
      input [1:0] idx;
      begin
         obj_entry = {8'h00, {6'h00, idx} + `THP_RID_CMD,
                      6'h00, `THP_CFG_BASE + {4'h0, idx, 4'h0}};
      end
   endfunction

   //-------------------------------------------------------------------------
   // State
   //-------------------------------------------------------------------------
   reg  [7:0]    cmd_last_r;
   reg  [3:0]    report_en_r;
   reg  [7:0]    cfg_r [0:NUM_CFG-1];
   reg  [7:0]    nvm_r [0:NUM_CFG-1];
   reg           nvm_valid_r;
   reg  [15:0]   nvm_cnt_r;
   reg           ovf_r;
   reg           boot_req_r;
   reg  [CNT_W-1:0] boot_len_r;
   reg  [23:0]   q_mem [0:DEPTH-1];
   reg  [Q_AW-1:0] q_wr_r;
   reg  [Q_AW-1:0] q_rd_r;
   reg  [Q_AW:0] q_cnt_r;
   reg  [Q_AW:0] q_cnt_nxt;
   reg  [31:0]   rd_val;
   reg           push;
   reg  [23:0]   push_msg;
   wire          boot_busy;
   wire          boot_done;
   integer       i;

   //-------------------------------------------------------------------------
   // Bus decode
   //-------------------------------------------------------------------------
   // A request is answered one cycle after it is seen; the commit edge is the
   // one at which the master samples waitrequest low.
   wire          req     = avs_read_in | avs_write_in;
   wire          commit  = req & ~avs_waitrequest_out;
   wire          wr_go   = commit & avs_write_in & avs_byteenable_in[0];
   wire          rd_go   = commit & avs_read_in;
   wire          is_cfg  = (avs_address_in[9:6] == `THP_CFG_PAGE);
   wire [3:0]    cfg_idx = avs_address_in[5:2];
   wire          cmd_wr  = wr_go & (avs_address_in == `THP_REG_COMMAND);
   wire [7:0]    cmd     = avs_writedata_in[7:0];
   wire          sw_rst  = cmd_wr & (cmd == `THP_CMD_RESET);
   wire          q_full  = (q_cnt_r == DEPTH[Q_AW:0]);
   wire          q_empty = (q_cnt_r == {(Q_AW+1){1'b0}});
   wire          pop     = rd_go & (avs_address_in == `THP_REG_MESSAGE) & ~q_empty;
   wire          touch_ok = touch_valid_in & report_en_r[touch_obj_in] & ~boot_busy; // [RULE_17]

   //-------------------------------------------------------------------------
   // Start-up timer
   //-------------------------------------------------------------------------
   thp_delay_timer #(.CNT_W(CNT_W)) u_boot
   (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .start_in (boot_req_r),
      .load_in  (boot_len_r),
      .busy_out (boot_busy),
      .done_out (boot_done)
   );

   //-------------------------------------------------------------------------
   // Message source selection
   //-------------------------------------------------------------------------
   // Only one message enters per cycle; device messages outrank touch reports.
   always @*
   begin
      push     = 1'b0;
      push_msg = 24'h000000;
      if (boot_done)
      begin
         push     = 1'b1; // [RULE_01] [RULE_19] [RULE_20] [RULE_21]
         push_msg = mk_msg(`THP_RID_CMD, `THP_MSG_RESET, {7'h00, nvm_valid_r});
      end
      else if (cmd_wr && cmd == `THP_CMD_CALIB)
      begin
         push     = 1'b1; // [RULE_09]
         push_msg = mk_msg(`THP_RID_CMD, `THP_MSG_CALIB, 8'h00);
      end
      else if (cmd_wr && cmd == `THP_CMD_BACKUP)
      begin
         push     = 1'b1; // [RULE_09]
         push_msg = mk_msg(`THP_RID_CMD, `THP_MSG_BACKUP, 8'h00);
      end
      else if (touch_ok)
      begin
         push     = 1'b1; // [RULE_17]
         push_msg = {{6'h00, touch_obj_in} + `THP_RID_CMD, touch_data_in};
      end
   end

   wire push_ok = push & ~q_full & ~sw_rst;
   // A touch is lost when the queue is full or a device message owns the cycle.
   wire dev_msg = boot_done | (cmd_wr & ((cmd == `THP_CMD_CALIB) | (cmd == `THP_CMD_BACKUP)));
   wire lost    = (push & q_full) | (touch_ok & dev_msg);

   always @*
   begin
      q_cnt_nxt = q_cnt_r;
      if (sw_rst)
         q_cnt_nxt = {(Q_AW+1){1'b0}};
      else if (push_ok && !pop)
         q_cnt_nxt = q_cnt_r + {{Q_AW{1'b0}}, 1'b1};
      else if (pop && !push_ok)
         q_cnt_nxt = q_cnt_r - {{Q_AW{1'b0}}, 1'b1};
   end

   //-------------------------------------------------------------------------
   // Read mux
   //-------------------------------------------------------------------------
   always @*
   begin
      rd_val = 32'h00000000;
      if (is_cfg)
         rd_val = {24'h000000, cfg_r[cfg_idx]};
      else if (avs_address_in[9:4] == `THP_OBJ_TBL_PAGE)
         rd_val = obj_entry(avs_address_in[3:2]);
      else
         case (avs_address_in)
            `THP_REG_STATUS:
               rd_val = {16'h0000, {(7-Q_AW){1'b0}}, q_cnt_r, 5'h00,
                         ovf_r, boot_busy, ~change_notify_n_out};
            `THP_REG_COMMAND:
               rd_val = {24'h000000, cmd_last_r};
            `THP_REG_MESSAGE:
               rd_val = q_empty ? {8'h00, `THP_RID_NONE, 16'h0000}
                                : {8'h00, q_mem[q_rd_r]}; // [RULE_09]
            `THP_REG_NVM_CNT:
               rd_val = {16'h0000, nvm_cnt_r};
            `THP_REG_REPORT_EN:
               rd_val = {28'h0000000, report_en_r};
            default:
               rd_val = 32'h00000000;
         endcase
   end

   //-------------------------------------------------------------------------
   // Bus handshake
   //-------------------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h00000000;
      end
      else
      begin
         avs_waitrequest_out <= ~(req & avs_waitrequest_out);
         if (req && avs_waitrequest_out)
            avs_readdata_out <= rd_val;
      end
   end

   //-------------------------------------------------------------------------
   // Command object, configuration fields and start-up sequencing
   //-------------------------------------------------------------------------
   // The nonvolatile copy is never reset: it models storage that survives.
   always @(posedge clk_in)
   begin
      if (wr_go && avs_write_in && cmd == `THP_CMD_BACKUP && cmd_wr)
      begin
         for (i = 0; i < NUM_CFG; i = i + 1)
            nvm_r[i] <= cfg_r[i]; // [RULE_07]
      end
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         for (i = 0; i < NUM_CFG; i = i + 1)
            cfg_r[i] <= 8'h00; // [RULE_12]
         report_en_r   <= 4'h0; // [RULE_12]
         cmd_last_r    <= 8'h00;
         nvm_valid_r   <= 1'b0;
         nvm_cnt_r     <= 16'h0000;
         boot_req_r    <= 1'b1;
         boot_len_r    <= POR_CYC[CNT_W-1:0]; // [RULE_19] [RULE_20]
         calibrate_out <= 1'b0;
      end
      else
      begin
         boot_req_r    <= sw_rst;
         calibrate_out <= cmd_wr & (cmd == `THP_CMD_CALIB); // [RULE_07]
         if (cmd_wr)
            cmd_last_r <= cmd;
         if (sw_rst)
         begin
            // A reset command reloads the stored settings, or zero if none.
            boot_len_r  <= SWR_CYC[CNT_W-1:0]; // [RULE_21]
            report_en_r <= 4'h0;
            for (i = 0; i < NUM_CFG; i = i + 1)
               cfg_r[i] <= nvm_valid_r ? nvm_r[i] : 8'h00; // [RULE_07]
         end
         else
         begin
            if (wr_go && is_cfg)
               cfg_r[cfg_idx] <= avs_writedata_in[7:0];
            if (wr_go && avs_address_in == `THP_REG_REPORT_EN)
               report_en_r <= avs_writedata_in[3:0];
         end
         if (cmd_wr && cmd == `THP_CMD_BACKUP)
         begin
            nvm_valid_r <= 1'b1; // [RULE_07]
            if (nvm_cnt_r != 16'hffff)
               nvm_cnt_r <= nvm_cnt_r + 16'h0001;
         end
      end
   end

   //-------------------------------------------------------------------------
   // Message queue and notify line
   //-------------------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (push_ok)
         q_mem[q_wr_r] <= push_msg;
   end

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         q_wr_r              <= {Q_AW{1'b0}};
         q_rd_r              <= {Q_AW{1'b0}};
         q_cnt_r             <= {(Q_AW+1){1'b0}};
         ovf_r               <= 1'b0;
         change_notify_n_out <= 1'b1;
      end
      else
      begin
         q_cnt_r <= q_cnt_nxt;
         if (sw_rst)
         begin
            q_wr_r <= {Q_AW{1'b0}};
            q_rd_r <= {Q_AW{1'b0}};
         end
         else
         begin
            if (push_ok)
               q_wr_r <= q_wr_r + {{(Q_AW-1){1'b0}}, 1'b1};
            if (pop)
               q_rd_r <= q_rd_r + {{(Q_AW-1){1'b0}}, 1'b1};
         end
         // Write one to clear; a new loss in the same cycle keeps it set.
         if (lost)
            ovf_r <= 1'b1;
         else if (wr_go && avs_address_in == `THP_REG_STATUS && avs_writedata_in[`THP_ST_OVF])
            ovf_r <= 1'b0;
         change_notify_n_out <= (q_cnt_nxt == {(Q_AW+1){1'b0}}); // [RULE_10] [RULE_22]
      end
   end

endmodule

// >>> verification/thp_object_if_asserts.sv
// Port checks for the object interface.
`timescale 1ns/1ps
module thp_object_if_asserts
#(
   parameter POR_CYC = 20,
   parameter SWR_CYC = 32
)
(
   input wire        clk_in,              // Clock.
   input wire        rst_in,              // Reset.
   input wire [9:0]  avs_address_in,      // Address.
   input wire        avs_read_in,         // Read.
   input wire        avs_write_in,        // Write.
   input wire [31:0] avs_writedata_in,    // Data in.
   input wire [3:0]  avs_byteenable_in,   // Enables.
   input wire [31:0] avs_readdata_out,    // Data out.
   input wire        avs_waitrequest_out, // Wait.
   input wire        change_notify_n_out, // Notify.
   input wire        calibrate_out        // Pulse.
);
   localparam int POR_LO = POR_CYC;
   localparam int POR_HI = POR_CYC + 6;
   localparam int SWR_LO = SWR_CYC - 4;
   localparam int SWR_HI = SWR_CYC + 6;
   reg  [7:0] since_rel_r;
   wire       cmd_go = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] && avs_address_in == 10'h004;
   wire       cal_go = cmd_go && avs_writedata_in[7:0] == 8'h03;
   wire       swr_go = cmd_go && avs_writedata_in[7:0] == 8'h01;
   wire       msg_rd = avs_read_in && !avs_waitrequest_out && avs_address_in == 10'h008;

   // The start-up window is measured from release so a notify that falls early shows.
   always @(posedge clk_in)
      if (rst_in)
         since_rel_r <= 8'h00;
      else if (since_rel_r != 8'hff)
         since_rel_r <= since_rel_r + 8'h01;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_ans;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   sequence s_cal;
      calibrate_out ##1 !calibrate_out;
   endsequence

   chk_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> s_ans)
      else $error("wait not low for one cycle");
   chk_wait_idle: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
      else $error("wait low without request");
   chk_rel_idle: assert property ($fell(rst_in) |-> avs_waitrequest_out && change_notify_n_out &&
      !calibrate_out && avs_readdata_out == 32'h0)
      else $error("outputs not idle after reset");
   chk_por_quiet: assert property (since_rel_r < POR_CYC |-> change_notify_n_out)
      else $error("notify fell too early");
   chk_por_fall: assert property ($fell(rst_in) |-> ##[POR_LO:POR_HI] !change_notify_n_out)
      else $error("notify late after reset");
   chk_swr_fall: assert property (swr_go |-> ##3 change_notify_n_out ##[SWR_LO:SWR_HI] !change_notify_n_out)
      else $error("notify wrong after reset command");
   chk_msg_notify: assert property (msg_rd |-> change_notify_n_out == (avs_readdata_out[23:16] == 8'hff))
      else $error("notify disagrees with message");
   chk_cal_pulse: assert property (cal_go |=> ##[0:1] s_cal)
      else $error("no calibrate pulse");
   chk_cal_cause: assert property (calibrate_out |-> $past(cal_go) || $past(cal_go, 2))
      else $error("calibrate pulse without command");
endmodule

bind thp_object_if thp_object_if_asserts #(.POR_CYC(POR_CYC), .SWR_CYC(SWR_CYC)) chk_u
(
   .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .change_notify_n_out(change_notify_n_out), .calibrate_out(calibrate_out)
);

// >>> verification/thp_host_model.sv
// Avalon-MM host processor model.
`timescale 1ns/1ps
module thp_host_model
(
   input  wire        clk_in,             // Clock.
   input  wire [31:0] avs_readdata_in,    // Data.
   input  wire        avs_waitrequest_in, // Wait.
   output reg  [9:0]  avs_address_out,    // Address.
   output reg         avs_read_out,       // Read.
   output reg         avs_write_out,      // Write.
   output reg  [31:0] avs_writedata_out,  // Data.
   output reg  [3:0]  avs_byteenable_out  // Enables.
);
   initial
   begin
      avs_address_out = 10'h000;
      avs_read_out = 1'b0;
      avs_write_out = 1'b0;
      avs_writedata_out = 32'h0;
      avs_byteenable_out = 4'h0;
   end

   // Holds the request until wait is seen low; ok stays low on a hang.
   task bus_access(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be,
                   output logic [31:0] q, output logic ok);
      int n;
      begin
         ok = 1'b0;
         q = 32'h0;
         @(posedge clk_in);
         avs_address_out <= a;
         avs_writedata_out <= d;
         avs_byteenable_out <= be;
         avs_write_out <= wr;
         avs_read_out <= !wr;
         for (n = 0; n < 50 && !ok; n++)
         begin
            @(posedge clk_in);
            ok = (avs_waitrequest_in === 1'b0);
         end
         q = avs_readdata_in;
         avs_write_out <= 1'b0;
         avs_read_out <= 1'b0;
      end
   endtask
endmodule

// >>> verification/thp_object_if_bench.sv
// Self-checking bench for the object interface.
`timescale 1ns/1ps
module thp_object_if_bench;
   logic        clk_in;
   logic        rst_in;
   logic        tv;
   logic [1:0]  tobj;
   logic [15:0] tdat;
   wire  [9:0]  addr;
   wire         rd_s;
   wire         wr_s;
   wire  [31:0] wdat;
   wire  [3:0]  be;
   wire  [31:0] rdat;
   wire         wait_s;
   wire         notify_n;
   wire         cal;
   int          fail_count = 0;
   int          checks = 0;
   int          cal_seen = 0;
   int          i;
   logic [31:0] nvm0;
   logic [31:0] cmd_tbl [2] = '{32'h03, 32'h02};
   logic [31:0] msg_tbl [2] = '{32'h011000, 32'h012000};

   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   always @(posedge clk_in)
      if (cal === 1'b1)
         cal_seen <= cal_seen + 1;

   thp_object_if #(.POR_CYC(20), .SWR_CYC(32), .Q_AW(3)) dut_u
   (
      .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd_s), .avs_write_in(wr_s),
      .avs_writedata_in(wdat), .avs_byteenable_in(be), .touch_valid_in(tv), .touch_obj_in(tobj),
      .touch_data_in(tdat), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_s),
      .change_notify_n_out(notify_n), .calibrate_out(cal)
   );
   thp_host_model host_u
   (
      .clk_in(clk_in), .avs_readdata_in(rdat), .avs_waitrequest_in(wait_s), .avs_address_out(addr),
      .avs_read_out(rd_s), .avs_write_out(wr_s), .avs_writedata_out(wdat), .avs_byteenable_out(be)
   );

   //------------------------------------------------------------------------
   // Tasks
   //------------------------------------------------------------------------
   task give_verdict;
      if (fail_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task hang;
      fail_count++;
      give_verdict();
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task acc(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] e, output logic [31:0] q);
      logic ok;
      begin
         host_u.bus_access(w, a, d, e, q, ok);
         if (!ok)
            hang();
      end
   endtask
   task wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] e);
      logic [31:0] q;
      acc(1'b1, a, d, e, q);
   endtask
   task rdc(input logic [9:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] q;
      begin
         acc(1'b0, a, 32'h0, 4'hf, q);
         check($sformatf("address %h", a), q & m, exp);
      end
   endtask
   task wait_notify;
      int n;
      begin
         for (n = 0; n < 200 && notify_n !== 1'b0; n++)
            @(posedge clk_in);
         if (notify_n !== 1'b0)
            hang();
      end
   endtask
   task touch(input logic [1:0] o, input logic [15:0] d);
      @(posedge clk_in);
      tv <= 1'b1;
      tobj <= o;
      tdat <= d;
      @(posedge clk_in);
      tv <= 1'b0;
   endtask

   //------------------------------------------------------------------------
   // Sequence
   //------------------------------------------------------------------------
   initial
   begin
      rst_in = 1'b1;
      tv = 1'b0;
      tobj = 2'h0;
      tdat = 16'h0;
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      rdc(10'h000, 32'h3, 32'h2);
      for (i = 0; i < 16; i++) rdc(10'(10'h100 + 4 * i), 32'hff, 32'h0);
      wait_notify();
      for (i = 0; i < 4; i++) rdc(10'(10'h040 + 4 * i), 32'hffffffff, {8'h0, 8'(i + 1), 16'(16'h100 + 16 * i)});
      rdc(10'h008, 32'hffff00, 32'h018000);
      rdc(10'h000, 32'hf07, 32'h0);
      check("notify", 32'(notify_n), 32'h1);
      rdc(10'h008, 32'hff0000, 32'hff0000);
      touch(2'h1, 16'h1234);
      repeat (4) @(posedge clk_in);
      check("notify", 32'(notify_n), 32'h1);
      wr(10'h010, 32'h2, 4'hf);
      touch(2'h1, 16'h1234);
      touch(2'h0, 16'h5555);
      wait_notify();
      rdc(10'h008, 32'hffffffff, 32'h021234);
      rdc(10'h000, 32'hf00, 32'h0);
      wr(10'h104, 32'h5a, 4'he);
      rdc(10'h104, 32'hff, 32'h0);
      wr(10'h104, 32'h5a, 4'h1);
      rdc(10'h104, 32'hff, 32'h5a);
      wr(10'h3fc, 32'hffffffff, 4'hf);
      rdc(10'h3fc, 32'hffffffff, 32'h0);
      acc(1'b0, 10'h00c, 32'h0, 4'hf, nvm0);
      for (i = 0; i < 2; i++)
      begin
         wr(10'h004, cmd_tbl[i], 4'h1);
         wait_notify();
         rdc(10'h008, 32'hffffff, msg_tbl[i]);
      end
      check("calibrate pulses", 32'(cal_seen), 32'h1);
      rdc(10'h004, 32'hff, 32'h2);
      rdc(10'h00c, 32'hffffffff, nvm0 + 32'h1);
      for (i = 0; i < 9; i++) touch(2'h1, 16'(i));
      rdc(10'h000, 32'hf04, 32'h804);
      wr(10'h000, 32'h4, 4'h1);
      rdc(10'h000, 32'h4, 32'h0);
      wr(10'h004, 32'h1, 4'h1);
      repeat (4) @(posedge clk_in);
      check("notify", 32'(notify_n), 32'h1);
      wait_notify();
      rdc(10'h008, 32'hffff00, 32'h018000);
      rdc(10'h104, 32'hff, 32'h5a);
      rdc(10'h010, 32'hf, 32'h0);
      wr(10'h010, 32'h1, 4'hf);
      touch(2'h0, 16'habcd);
      wait_notify();
      rdc(10'h008, 32'hffffffff, 32'h01abcd);
      rdc(10'h000, 32'hf04, 32'h0);
      rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      wait_notify();
      rdc(10'h008, 32'hffff00, 32'h018000);
      give_verdict();
   end
endmodule
